// ==== scwd_pkg.sv ====
/*
 * scwd_pkg: shared constants and carriers of the synthesizer control word decoder.
 * Assumes: included before every other file of the block.
 */
`default_nettype none
package scwd_pkg;
	localparam int WORD_W = 26;
	localparam logic [1:0] ADDR_OPMODE = 2'h0;
	localparam logic [1:0] ADDR_CAL    = 2'h1;
	localparam logic [1:0] ADDR_FREQ1  = 2'h2;
	localparam logic [1:0] ADDR_FREQ2  = 2'h3;
	localparam int ADDR_LSB = 0;
	localparam int ADDR_MSB = 1;
	// operation mode word fields
	localparam int DIAG_LSB = 15;
	localparam int DIAG_MSB = 17;
	localparam int BIAS_LSB = 21;
	localparam int BIAS_MSB = 22;
	localparam int PRE_BIT  = 23;
	// calibration word fields
	localparam int CALCTL_LSB = 2;
	localparam int CALCTL_MSB = 19;
	localparam int CALEN_BIT  = 20;
	// first frequency word fields
	localparam int RDIV_LSB = 2;
	localparam int RDIV_MSB = 3;
	localparam int MCNT_LSB = 10;
	localparam int MCNT_MSB = 15;
	localparam int ACNT_LSB = 6;
	localparam int ACNT_MSB = 9;
	localparam int MODRUN_BIT = 17;
	localparam int FRAC_BIT   = 18;
	localparam int MELO_LSB = 20;
	localparam int MELO_MSB = 23;
	// second frequency word fields
	localparam int MEHI_LSB = 2;
	localparam int MEHI_MSB = 12;
	// diagnostic select codes
	localparam logic [2:0] DIAG_LOCK = 3'h0;
	localparam logic [2:0] DIAG_RDIV = 3'h1;
	localparam logic [2:0] DIAG_NDIV = 3'h2;
	localparam logic [2:0] DIAG_CAL  = 3'h7;
	// reset values (recommended operating values)
	localparam logic [25:0] OPMODE_RST = 26'h0000000;
	localparam logic [25:0] CAL_RST    = 26'h0000001;
	localparam logic [25:0] FREQ1_RST  = 26'h00e0002;
	localparam logic [25:0] FREQ2_RST  = 26'h0000003;
	localparam logic [4:0]  BITS_LAST  = 5'h19;

	typedef struct packed {
		logic [2:0]  diag_sel;
		logic [1:0]  pre_bias;
		logic        pre_16_17;
		logic        cal_en;
		logic [17:0] cal_ctl;
		logic [3:0]  ref_div_log;
		logic [5:0]  m_count;
		logic [3:0]  a_count;
		logic        mod_run;
		logic        mod_frac;
		logic [14:0] modulus_extender;
	} scwd_cfg_type;

	typedef struct packed {
		logic                valid;
		logic [WORD_W-1:0]   data;
	} scwd_word_type;
endpackage : scwd_pkg
`default_nettype wire

// ==== scwd_shift.sv ====
/*
 * scwd_shift: serial port front end on the link clock; collects 26 bits msb first.
 * Assumes: the load strobe is high while the word shifts and falls after the last bit.
 */
`timescale 1ns/10ps
`default_nettype none
module scwd_shift (
	// link side
	input  wire logic                       link_clk,
	input  wire logic                       link_rst_b,
	input  wire logic                       ser_data,
	input  wire logic                       ser_enable,
	// system side
	output var  logic [scwd_pkg::WORD_W-1:0] word_ff,
	output var  logic                       word_tgl_ff
);
	logic [scwd_pkg::WORD_W-1:0] shreg_ff;
	logic [4:0]                  cnt_ff;

	always_ff @(posedge link_clk or negedge link_rst_b) begin
		if (!link_rst_b) begin
			shreg_ff    <= '0;
			cnt_ff      <= '0;
			word_ff     <= '0;
			word_tgl_ff <= 1'b0;
		end else if (ser_enable) begin
			shreg_ff <= {shreg_ff[scwd_pkg::WORD_W-2:0], ser_data};
			if (cnt_ff == scwd_pkg::BITS_LAST) begin
				// only a full word is published
				cnt_ff      <= '0;
				word_ff     <= {shreg_ff[scwd_pkg::WORD_W-2:0], ser_data};
				word_tgl_ff <= ~word_tgl_ff;
			end else begin
				cnt_ff <= cnt_ff + 5'h01;
			end
		end else begin
			// short frames are dropped
			cnt_ff <= '0;
		end
	end
endmodule : scwd_shift
`default_nettype wire

// ==== scwd_sync.sv ====
/*
 * scwd_sync: two-flop synchroniser for one level.
 * Assumes: the destination clock samples the level at least twice per change.
 */
`timescale 1ns/10ps
`default_nettype none
module scwd_sync (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic din,
	output var  logic dout_ff
);
	logic meta_ff;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= 1'b0;
			dout_ff <= 1'b0;
		end else begin
			meta_ff <= din;
			dout_ff <= meta_ff;
		end
	end
endmodule : scwd_sync

// ==== scwd_top.sv ====
/*
 * scwd_top: decoder of the serially loaded control words of a fractional-N synthesizer.
 * Assumes: words arrive on the three-wire port; lock and divider signals come from the loop.
 */
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Address 01 goes to the calibration register and 10 to the first frequency register.
// - Address 00 goes to the operation mode register.
// - Address 11 goes to the second frequency register.
// - Operation mode bits 17:15 choose what the lock pin shows, lock status by default.
// - Operation mode bit 23 picks the 8/9 prescaler at 0 and 16/17 at 1.
// - Operation mode bits 22:21 set the prescaler bias, 00 being the normal value.
// - Calibration bit 20 enables the digital calibration loop.
// - First frequency bits 3:2 set reference divide 8, 4, 2 or 1.
// - First frequency bits 15:10 load the M counter and bits 9:6 the A counter.
// - In 8/9 mode the A counter uses three bits and bit 9 is ignored.
// - First frequency bit 17 holds the modulator in reset at 0 and runs it at 1.
// - First frequency bit 18 selects integer at 0 and fractional at 1.
// - First frequency bits 23:20 are modulus extender bits 3:0.
// - Second frequency bits 12:2 are modulus extender bits 14:4.
module scwd_top (
	// system
	input  wire logic                SYS_CLK,
	input  wire logic                RST_B,
	// serial port
	input  wire logic                SER_CLK,
	input  wire logic                SER_DATA,
	input  wire logic                SER_ENABLE,
	// loop status from the analog side
	input  wire logic                LOCK_IN,
	input  wire logic                RDIV_IN,
	input  wire logic                NDIV_IN,
	input  wire logic                CALTEST_IN,
	// outputs
	output var  logic                LOCK_PIN_FF,
	output var  scwd_pkg::scwd_cfg_type CFG_FF
);
	////////////////////////////////////////////////////////////////////////////
	logic                        rst_meta_ff;
	logic                        rst_sync_ff;
	logic                        link_rst_b;
	logic [scwd_pkg::WORD_W-1:0] link_word;
	logic                        link_tgl;
	logic                        tgl_sync;
	logic                        tgl_seen_ff;
	logic [scwd_pkg::WORD_W-1:0] word_cap_ff;
	logic                        new_word;
	logic                        lock_s;
	logic                        rdiv_s;
	logic                        ndiv_s;
	logic                        cal_s;

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// link side reset follows the pin directly; it has no edges of its own to sync on
	assign link_rst_b = RST_B;

	////////////////////////////////////////////////////////////////////////////
	scwd_shift u_shift (
		.link_clk    (SER_CLK),
		.link_rst_b  (link_rst_b),
		.ser_data    (SER_DATA),
		.ser_enable  (SER_ENABLE),
		.word_ff     (link_word),
		.word_tgl_ff (link_tgl)
	);

	scwd_sync u_tgl_sync (.clk(SYS_CLK), .rst_b(rst_sync_ff), .din(link_tgl), .dout_ff(tgl_sync));
	scwd_sync u_lock_sync (.clk(SYS_CLK), .rst_b(rst_sync_ff), .din(LOCK_IN), .dout_ff(lock_s));
	scwd_sync u_rdiv_sync (.clk(SYS_CLK), .rst_b(rst_sync_ff), .din(RDIV_IN), .dout_ff(rdiv_s));
	scwd_sync u_ndiv_sync (.clk(SYS_CLK), .rst_b(rst_sync_ff), .din(NDIV_IN), .dout_ff(ndiv_s));
	scwd_sync u_cal_sync (.clk(SYS_CLK), .rst_b(rst_sync_ff), .din(CALTEST_IN), .dout_ff(cal_s));

	// the word register on the link side is stable for many system cycles after a toggle
	assign new_word = tgl_sync ^ tgl_seen_ff;

	always_ff @(posedge SYS_CLK or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			tgl_seen_ff <= 1'b0;
			word_cap_ff <= '0;
		end else begin
			tgl_seen_ff <= tgl_sync;
			if (new_word) begin
				word_cap_ff <= link_word;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// address decode
	logic        cap_pend_ff;
	logic [1:0]  word_address_bits;
	logic        wr_opmode;
	logic        wr_cal;
	logic        wr_freq1;
	logic        wr_freq2;

	always_ff @(posedge SYS_CLK or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			cap_pend_ff <= 1'b0;
		end else begin
			cap_pend_ff <= new_word;
		end
	end

	assign word_address_bits = word_cap_ff[scwd_pkg::ADDR_MSB:scwd_pkg::ADDR_LSB];
	assign wr_opmode = cap_pend_ff && (word_address_bits == scwd_pkg::ADDR_OPMODE);
	assign wr_cal    = cap_pend_ff && (word_address_bits == scwd_pkg::ADDR_CAL);
	assign wr_freq1  = cap_pend_ff && (word_address_bits == scwd_pkg::ADDR_FREQ1);
	assign wr_freq2  = cap_pend_ff && (word_address_bits == scwd_pkg::ADDR_FREQ2);

	////////////////////////////////////////////////////////////////////////////
	// word registers
	logic [scwd_pkg::WORD_W-1:0] operation_mode_ff;
	logic [scwd_pkg::WORD_W-1:0] calibration_control_ff;
	logic [scwd_pkg::WORD_W-1:0] frequency_control_low_ff;
	logic [scwd_pkg::WORD_W-1:0] frequency_control_high_ff;

	always_ff @(posedge SYS_CLK or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			operation_mode_ff         <= scwd_pkg::OPMODE_RST;
			calibration_control_ff    <= scwd_pkg::CAL_RST;
			frequency_control_low_ff  <= scwd_pkg::FREQ1_RST;
			frequency_control_high_ff <= scwd_pkg::FREQ2_RST;
		end else begin
			// each word lands only in its own register
			if (wr_opmode) begin
				operation_mode_ff <= word_cap_ff;
			end
			if (wr_cal) begin
				calibration_control_ff <= word_cap_ff;
			end
			if (wr_freq1) begin
				frequency_control_low_ff <= word_cap_ff;
			end
			if (wr_freq2) begin
				frequency_control_high_ff <= word_cap_ff;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// field decode
	logic [2:0]  diag_sel;
	logic        pre_16_17;
	logic [1:0]  rdiv_code;
	logic [3:0]  nxt_ref_div_log;
	logic [3:0]  a_raw;
	logic [3:0]  nxt_a_count;
	logic [14:0] nxt_modulus_extender;
	scwd_pkg::scwd_cfg_type nxt_cfg;
	logic        nxt_lock_pin;

	assign diag_sel  = operation_mode_ff[scwd_pkg::DIAG_MSB:scwd_pkg::DIAG_LSB];
	assign pre_16_17 = operation_mode_ff[scwd_pkg::PRE_BIT];
	assign rdiv_code = frequency_control_low_ff[scwd_pkg::RDIV_MSB:scwd_pkg::RDIV_LSB];
	// one-hot divide ratio: 00 -> 8, 01 -> 4, 10 -> 2, 11 -> 1
	assign nxt_ref_div_log = 4'h8 >> rdiv_code;
	assign a_raw = frequency_control_low_ff[scwd_pkg::ACNT_MSB:scwd_pkg::ACNT_LSB];
	assign nxt_a_count = pre_16_17 ? a_raw : {1'b0, a_raw[2:0]};
	assign nxt_modulus_extender = {
		frequency_control_high_ff[scwd_pkg::MEHI_MSB:scwd_pkg::MEHI_LSB],
		frequency_control_low_ff[scwd_pkg::MELO_MSB:scwd_pkg::MELO_LSB]
	};

	assign nxt_cfg.diag_sel    = diag_sel;
	assign nxt_cfg.pre_bias    = operation_mode_ff[scwd_pkg::BIAS_MSB:scwd_pkg::BIAS_LSB];
	assign nxt_cfg.pre_16_17   = pre_16_17;
	assign nxt_cfg.cal_en      = calibration_control_ff[scwd_pkg::CALEN_BIT];
	assign nxt_cfg.cal_ctl     = calibration_control_ff[scwd_pkg::CALCTL_MSB:scwd_pkg::CALCTL_LSB];
	assign nxt_cfg.ref_div_log = nxt_ref_div_log;
	assign nxt_cfg.m_count     = frequency_control_low_ff[scwd_pkg::MCNT_MSB:scwd_pkg::MCNT_LSB];
	assign nxt_cfg.a_count     = nxt_a_count;
	assign nxt_cfg.mod_run     = frequency_control_low_ff[scwd_pkg::MODRUN_BIT];
	assign nxt_cfg.mod_frac    = frequency_control_low_ff[scwd_pkg::FRAC_BIT];
	assign nxt_cfg.modulus_extender = nxt_modulus_extender;

	// lock pin multiplexer; unused codes show lock status
	assign nxt_lock_pin = (diag_sel == scwd_pkg::DIAG_RDIV) ? rdiv_s :
	                      (diag_sel == scwd_pkg::DIAG_NDIV) ? ndiv_s :
	                      (diag_sel == scwd_pkg::DIAG_CAL)  ? cal_s  : lock_s;

	always_ff @(posedge SYS_CLK or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			LOCK_PIN_FF <= 1'b0;
			CFG_FF      <= '0;
		end else begin
			LOCK_PIN_FF <= nxt_lock_pin;
			CFG_FF      <= nxt_cfg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	route_cal_a: assert property (@(posedge SYS_CLK) disable iff (!rst_sync_ff)
		(cap_pend_ff && word_address_bits == 2'h1) |=> (calibration_control_ff == $past(word_cap_ff)))
		else $error("calibration word not routed");

	route_freq1_a: assert property (@(posedge SYS_CLK) disable iff (!rst_sync_ff)
		(cap_pend_ff && word_address_bits == 2'h2) |=> (frequency_control_low_ff == $past(word_cap_ff)))
		else $error("first frequency word not routed");

	route_opmode_a: assert property (@(posedge SYS_CLK) disable iff (!rst_sync_ff)
		(cap_pend_ff && word_address_bits == 2'h0) |=> (operation_mode_ff == $past(word_cap_ff)))
		else $error("operation mode word not routed");

	route_freq2_a: assert property (@(posedge SYS_CLK) disable iff (!rst_sync_ff)
		(cap_pend_ff && word_address_bits == 2'h3) |=> (frequency_control_high_ff == $past(word_cap_ff)))
		else $error("second frequency word not routed");

	lock_default_a: assert property (@(posedge SYS_CLK) disable iff (!rst_sync_ff)
		(diag_sel == 3'h0) |=> (LOCK_PIN_FF == $past(lock_s)))
		else $error("lock pin not showing lock status");

	a_count_mask_a: assert property (@(posedge SYS_CLK) disable iff (!rst_sync_ff)
		!$past(pre_16_17) |-> (CFG_FF.a_count[3] == 1'b0))
		else $error("a counter bit 3 used in 8/9 mode");

	ref_div_a: assert property (@(posedge SYS_CLK) disable iff (!rst_sync_ff)
		rst_sync_ff && (rdiv_code == 2'h0) |=> (CFG_FF.ref_div_log == 4'h8))
		else $error("reference divide not 8 for code 00");

	ext_join_a: assert property (@(posedge SYS_CLK) disable iff (!rst_sync_ff)
		rst_sync_ff |=> (CFG_FF.modulus_extender[14:4] == $past(frequency_control_high_ff[12:2])
		       && CFG_FF.modulus_extender[3:0] == $past(frequency_control_low_ff[23:20])))
		else $error("modulus extender assembled wrongly");

	others_hold_a: assert property (@(posedge SYS_CLK) disable iff (!rst_sync_ff)
		!cap_pend_ff |=> $stable(operation_mode_ff) && $stable(frequency_control_low_ff)
		              && $stable(calibration_control_ff) && $stable(frequency_control_high_ff))
		else $error("register changed without a word");
endmodule : scwd_top
`default_nettype wire

// ==== scwd_host_model.sv ====
/*
 * scwd_host_model: host controller that shifts control words into the serial port.
 * Assumes: the bench calls send between system clock edges; one word at a time.
 */
`timescale 1ns/10ps
`default_nettype none
module scwd_host_model (
	// serial port
	output var logic ser_clk,
	output var logic ser_data,
	output var logic ser_enable
);
	localparam time HALF = 24ns;

	initial begin
		ser_clk    = 1'b0;
		ser_data   = 1'b0;
		ser_enable = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// msb first; address stays in bits 1:0 of the word
	task automatic send(input logic [25:0] word, input int nbits);
		int i;
		if (word[1:0] == 2'h2) begin
			word[19] = 1'b1;
		end
		ser_enable = 1'b1;
		for (i = 25; i > 25 - nbits; i--) begin
			ser_data = word[i];
			#HALF ser_clk = 1'b1;
			#HALF ser_clk = 1'b0;
		end
		ser_enable = 1'b0;
		// released data line: no pull, so show the inverse
		ser_data = ~ser_data;
		// one idle edge with the strobe low closes the frame
		#HALF ser_clk = 1'b1;
		#HALF ser_clk = 1'b0;
	endtask : send
endmodule : scwd_host_model
`default_nettype wire

// ==== scwd_top_tb.sv ====
/*
 * scwd_top_tb: self-checking bench of the control word decoder.
 * Assumes: scwd_pkg, scwd_top and scwd_host_model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module scwd_top_tb;
	typedef struct packed {
		logic [25:0] word;
		logic [3:0]  loop;
		logic        pin;
	} scwd_row_type;

	logic                   sys_clk;
	logic                   rst_b;
	logic                   ser_clk;
	logic                   ser_data;
	logic                   ser_enable;
	logic [3:0]             loop;
	logic                   lock_pin;
	scwd_pkg::scwd_cfg_type cfg;
	logic [25:0]            regs [4];
	int                     mismatches;
	int                     samples_checked;
	int                     cycles;
	int                     r;

	// loop is {caltest, ndiv, rdiv, lock}
	localparam scwd_row_type ROWS [13] = '{
		'{26'h0800000, 4'h1, 1'b1}, '{26'h0e08000, 4'h2, 1'b1},
		'{26'h0010000, 4'hb, 1'b0}, '{26'h0038000, 4'h8, 1'b1},
		'{26'h0018000, 4'h1, 1'b1}, '{26'h01ffffd, 4'h1, 1'b1},
		'{26'h00aaaa9, 4'he, 1'b0}, '{26'h0feffc2, 4'h1, 1'b1},
		'{26'h05a000a, 4'h1, 1'b1}, '{26'h008000e, 4'h1, 1'b1},
		'{26'h00c0206, 4'h1, 1'b1}, '{26'h0001fff, 4'h1, 1'b1},
		'{26'h0800000, 4'h1, 1'b1}};

	scwd_top i_scwd_top (
		.SYS_CLK     (sys_clk),
		.RST_B       (rst_b),
		.SER_CLK     (ser_clk),
		.SER_DATA    (ser_data),
		.SER_ENABLE  (ser_enable),
		.LOCK_IN     (loop[0]),
		.RDIV_IN     (loop[1]),
		.NDIV_IN     (loop[2]),
		.CALTEST_IN  (loop[3]),
		.LOCK_PIN_FF (lock_pin),
		.CFG_FF      (cfg)
	);

	scwd_host_model i_scwd_host_model (
		.ser_clk    (ser_clk),
		.ser_data   (ser_data),
		.ser_enable (ser_enable)
	);

	always #50 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic scwd_pkg::scwd_cfg_type decode();
		scwd_pkg::scwd_cfg_type c;
		c.diag_sel         = regs[0][17:15];
		c.pre_bias         = regs[0][22:21];
		c.pre_16_17        = regs[0][23];
		c.cal_en           = regs[1][20];
		c.cal_ctl          = regs[1][19:2];
		c.ref_div_log      = 4'h8 >> regs[2][3:2];
		c.m_count          = regs[2][15:10];
		c.a_count          = {regs[2][9] & regs[0][23], regs[2][8:6]};
		c.mod_run          = regs[2][17];
		c.mod_frac         = regs[2][18];
		c.modulus_extender = {regs[3][12:2], regs[2][23:20]};
		return c;
	endfunction : decode

	task automatic check(input string what, input logic [60:0] exp, input logic [60:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic put(input logic [25:0] word, input int nbits);
		i_scwd_host_model.send(word, nbits);
		if (nbits == 26) begin
			regs[word[1:0]] = word;
		end
	endtask : put

	task automatic settle();
		repeat (10) @(posedge sys_clk);
		#5;
	endtask : settle

	task automatic do_reset();
		rst_b = 1'b0;
		regs  = '{scwd_pkg::OPMODE_RST, scwd_pkg::CAL_RST, scwd_pkg::FREQ1_RST,
			scwd_pkg::FREQ2_RST};
		repeat (20) @(posedge sys_clk);
		check("cfg in reset", 61'h0, cfg);
		check("pin in reset", 61'h0, {60'h0, lock_pin});
		#5 rst_b = 1'b1;
		settle();
		check("cfg after reset", decode(), cfg);
	endtask : do_reset

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk         = 1'b0;
		rst_b           = 1'b0;
		loop            = 4'h1;
		mismatches      = 0;
		samples_checked = 0;
		cycles          = 0;
		do_reset();
		for (r = 0; r < 13; r++) begin
			loop = ROWS[r].loop;
			put(ROWS[r].word, 26);
			settle();
			check("cfg row", decode(), cfg);
			check("pin row", {60'h0, ROWS[r].pin}, {60'h0, lock_pin});
		end
		// cut word dropped, then two whole words back to back
		put(26'h3ffffff, 12);
		settle();
		check("cfg after cut word", decode(), cfg);
		put(26'h0000ab7, 26);
		put(26'h0010000, 26);
		settle();
		check("cfg back to back", decode(), cfg);
		do_reset();
		// link toggle restarts cleanly after a reset in mid-run
		put(ROWS[0].word, 26);
		settle();
		check("cfg after second reset", decode(), cfg);
		conclude();
	end
endmodule : scwd_top_tb
`default_nettype wire
